// File: inc/css_defines.svh
/*
  Offsets, field positions, reset values and timing counts of the command set switch.
  Assumes an 8-bit AXI4-Lite byte address and a 4 ns clock.
*/
`ifndef CSS_DEFINES_SVH
`define CSS_DEFINES_SVH

`define CSS_ADDR_W        8
`define CSS_SET_W         16
`define CSS_NUM_SETS      4
`define CSS_REG_COMM      8'h00
`define CSS_REG_COUNT     8'h04
`define CSS_REG_ACTIVE    8'h08
`define CSS_REG_COPY      8'h0c
`define CSS_REG_SET0      8'h10
`define CSS_COMM_EDIT     4'hf
`define CSS_COMM_READY    4'h0
`define CSS_COUNT_RST     3'h2
`define CSS_COUNT_MIN     3'h2
`define CSS_COUNT_MAX     3'h4
`define CSS_COPY_SRC_LSB  0
`define CSS_COPY_TGT_LSB  4
`define CSS_COPY_START    8
`define CSS_ACTIVE_BUSY   8
`define CSS_RESP_OKAY     2'h0
`define CSS_RESP_SLVERR   2'h2
`define CSS_CLK_NS        4
`define CSS_SWITCH_NS     4000000
`define CSS_SWITCH_CYC    (`CSS_SWITCH_NS / `CSS_CLK_NS)

`endif

// File: inc/css_pkg.sv
/*
  Types shared by the command set switch.
  Assumes css_defines.svh supplies the numeric constants.
*/
package css_pkg;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_FETCH = 4'b0010,
    ST_APPLY = 4'b0100,
    ST_COPY  = 4'b1000
  } css_state_type;

  typedef logic [1:0]  css_idx_type;
  typedef logic [15:0] css_word_type;

endpackage

// File: src/css_set_mem.sv
/*
  Storage of the four command sets, one write port and two registered read ports.
  Assumes one writer per cycle; the caller arbitrates.
*/
`timescale 1ns/1ps
`include "css_defines.svh"

module css_set_mem
  import css_pkg::*;
(
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic         wr_en,
  input  wire css_idx_type  wr_addr,
  input  wire css_word_type wr_data,
  input  wire css_idx_type  rd_addr_a,
  output css_word_type      rd_data_a,
  input  wire css_idx_type  rd_addr_b,
  output css_word_type      rd_data_b
);

  css_word_type mem [`CSS_NUM_SETS];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < `CSS_NUM_SETS; i++) begin
        mem[i] <= 16'h0000;
      end
    end else if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_data_a <= 16'h0000;
      rd_data_b <= 16'h0000;
    end else begin
      rd_data_a <= mem[rd_addr_a];
      rd_data_b <= mem[rd_addr_b];
    end
  end

endmodule // css_set_mem

// File: src/css_switch.sv
/*
  Command set switch: picks the active command set from two select pins and routes
  each command bit from the fieldbus word or the terminal strip. Registers over AXI4-Lite.
  Assumes select and terminal pins are asynchronous; the fieldbus word is on aclk.
*/
// Decided for this implementation: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "css_defines.svh"

module css_switch
  import css_pkg::*;
#(
  parameter int SWITCH_CYC = `CSS_SWITCH_CYC
)
(
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  input  wire logic [`CSS_ADDR_W-1:0] awaddr,
  input  wire logic [2:0]             awprot,
  input  wire logic                   awvalid,
  output logic                        awready,
  input  wire logic [31:0]            wdata,
  input  wire logic [3:0]             wstrb,
  input  wire logic                   wvalid,
  output logic                        wready,
  output logic [1:0]                  bresp,
  output logic                        bvalid,
  input  wire logic                   bready,
  input  wire logic [`CSS_ADDR_W-1:0] araddr,
  input  wire logic [2:0]             arprot,
  input  wire logic                   arvalid,
  output logic                        arready,
  output logic [31:0]                 rdata,
  output logic [1:0]                  rresp,
  output logic                        rvalid,
  input  wire logic                   rready,
  input  wire logic                   set_select_bit_low,
  input  wire logic                   set_select_bit_high,
  input  wire css_word_type           term_cmd,
  input  wire css_word_type           fb_cmd,
  output css_word_type                cmd_word,
  output css_idx_type                 active_set_indicator
);

  function automatic logic [31:0] merge_strb(input logic [31:0] old_v, input logic [31:0] new_v,
                                             input logic [3:0] strb);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return res;
  endfunction

  function automatic logic is_mapped(input logic [`CSS_ADDR_W-1:0] addr);
    return (addr[7:5] == 3'h0) && (addr[1:0] == 2'h0);
  endfunction

  function automatic logic is_set_win(input logic [`CSS_ADDR_W-1:0] addr);
    return is_mapped(addr) && addr[4];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Registers and state

  css_state_type  state;
  logic [3:0]     commissioning_state;
  logic [2:0]     set_count_config;
  css_idx_type    copy_src;
  css_idx_type    copy_tgt;
  logic           copy_start;
  css_idx_type    active;
  css_idx_type    pend_idx;
  css_word_type   set_word;
  logic           reload;
  logic [1:0]     sel_meta;
  logic [1:0]     sel_sync;
  css_idx_type    sel_hold;
  css_word_type   term_meta;
  css_word_type   term_sync;
  logic           rd_pend;
  logic [`CSS_ADDR_W-1:0] rd_addr;
  css_word_type   mem_rd_a;
  css_word_type   mem_rd_b;
  css_idx_type    mem_addr_b;
  logic           mem_we;
  css_idx_type    mem_waddr;
  css_word_type   mem_wdata;
  css_idx_type    sel_idx;
  css_idx_type    tgt_idx;
  logic           wr_fire;
  logic           want_switch;
  logic           copy_ok;
  logic           copy_clear;
  logic           reload_set;
  logic [31:0]    next_comm;
  logic [31:0]    next_count;
  logic [31:0]    next_copy;

  function automatic logic in_range(input css_idx_type idx, input logic [2:0] cnt);
    return {1'b0, idx} < cnt;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sel_meta  <= 2'h0;
      sel_sync  <= 2'h0;
      sel_hold  <= 2'h0;
      term_meta <= 16'h0000;
      term_sync <= 16'h0000;
    end else begin
      sel_meta  <= {set_select_bit_high, set_select_bit_low};
      sel_sync  <= sel_meta;
      sel_hold  <= sel_sync;
      term_meta <= term_cmd;
      term_sync <= term_meta;
    end
  end

  assign sel_idx = {sel_sync[1], sel_sync[0]};

  ////////////////////////////////////////////////////////////////////////////
  // AXI write side

  // Copy engine owns the write port while copying
  assign wr_fire = awvalid && wvalid && !bvalid && (state != ST_COPY);
  assign awready = wr_fire;
  assign wready  = wr_fire;

  always_comb begin
    next_comm  = merge_strb({28'h0, commissioning_state}, wdata, wstrb);
    next_count = merge_strb({29'h0, set_count_config}, wdata, wstrb);
    next_copy  = merge_strb({23'h0, copy_start, 2'h0, copy_tgt, 2'h0, copy_src}, wdata, wstrb);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp  <= `CSS_RESP_OKAY;
    end else if (wr_fire) begin
      bvalid <= 1'b1;
      bresp  <= is_mapped(awaddr) ? `CSS_RESP_OKAY : `CSS_RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      commissioning_state <= `CSS_COMM_READY;
    end else if (wr_fire && awaddr == `CSS_REG_COMM) begin
      commissioning_state <= next_comm[3:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      set_count_config <= `CSS_COUNT_RST;
    end else if (wr_fire && awaddr == `CSS_REG_COUNT && commissioning_state == `CSS_COMM_EDIT
                 && next_count[2:0] >= `CSS_COUNT_MIN && next_count[2:0] <= `CSS_COUNT_MAX) begin
      set_count_config <= next_count[2:0];
    end
  end

  // Copy fields frozen while a copy is pending; start set wins over clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      copy_src   <= 2'h0;
      copy_tgt   <= 2'h0;
      copy_start <= 1'b0;
    end else if (wr_fire && awaddr == `CSS_REG_COPY && !copy_start) begin
      copy_src   <= next_copy[`CSS_COPY_SRC_LSB +: 2];
      copy_tgt   <= next_copy[`CSS_COPY_TGT_LSB +: 2];
      copy_start <= next_copy[`CSS_COPY_START];
    end else if (copy_clear) begin
      copy_start <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI read side

  assign arready = !rvalid && !rd_pend;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_pend <= 1'b0;
      rd_addr <= 8'h00;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= `CSS_RESP_OKAY;
    end else if (arvalid && arready) begin
      rd_pend <= 1'b1;
      rd_addr <= araddr;
    end else if (rd_pend) begin
      rd_pend <= 1'b0;
      rvalid  <= 1'b1;
      rresp   <= is_mapped(rd_addr) ? `CSS_RESP_OKAY : `CSS_RESP_SLVERR;
      if (is_set_win(rd_addr)) begin
        rdata <= {16'h0000, mem_rd_a};
      end else begin
        case (rd_addr)
          `CSS_REG_COMM:   rdata <= {28'h0, commissioning_state};
          `CSS_REG_COUNT:  rdata <= {29'h0, set_count_config};
          `CSS_REG_ACTIVE: rdata <= {23'h0, state != ST_IDLE, 6'h0, active};
          `CSS_REG_COPY:   rdata <= {23'h0, copy_start, 2'h0, copy_tgt, 2'h0, copy_src};
          default:         rdata <= 32'h0000_0000;
        endcase
      end
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Set storage

  always_comb begin
    mem_we    = 1'b0;
    mem_waddr = copy_tgt;
    mem_wdata = mem_rd_b;
    if (state == ST_COPY) begin
      mem_we = 1'b1;
    end else if (wr_fire && is_set_win(awaddr) && wstrb[1:0] == 2'h3) begin
      mem_we    = 1'b1;
      mem_waddr = awaddr[3:2];
      mem_wdata = wdata[15:0];
    end
  end

  assign mem_addr_b = (copy_start || state == ST_COPY) ? copy_src : tgt_idx;

  css_set_mem u_mem (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .wr_en     (mem_we),
    .wr_addr   (mem_waddr),
    .wr_data   (mem_wdata),
    .rd_addr_a (araddr[3:2]),
    .rd_data_a (mem_rd_a),
    .rd_addr_b (mem_addr_b),
    .rd_data_b (mem_rd_b)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Switchover and copy engine

  // Out-of-range select is ignored: the last good set stays in force
  assign tgt_idx     = in_range(sel_idx, set_count_config) ? sel_idx : active;
  // Two pins may resolve a cycle apart: launch only on a select seen alike twice
  assign want_switch = (sel_idx == sel_hold) && (tgt_idx != active || reload);
  assign copy_ok     = in_range(copy_src, set_count_config) && in_range(copy_tgt, set_count_config);
  assign copy_clear  = (state == ST_COPY) || (state == ST_IDLE && copy_start && !copy_ok);
  // Any write to the live, fetching or wanted set forces a refetch
  assign reload_set  = mem_we && (mem_waddr == active || mem_waddr == pend_idx || mem_waddr == tgt_idx);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state    <= ST_IDLE;
      pend_idx <= 2'h0;
      active   <= 2'h0;
      set_word <= 16'h0000;
    end else begin
      case (state)
        ST_IDLE: begin
          if (copy_start) begin
            if (copy_ok) begin
              state <= ST_COPY;
            end
          end else if (want_switch) begin
            pend_idx <= tgt_idx;
            state    <= ST_FETCH;
          end
        end
        ST_FETCH: begin
          set_word <= mem_rd_b;
          state    <= ST_APPLY;
        end
        ST_APPLY: begin
          active <= pend_idx;
          state  <= ST_IDLE;
        end
        ST_COPY: begin
          state <= ST_IDLE;
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // Refetch when the live set is rewritten; a new rewrite beats the clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      reload <= 1'b1;
    end else if (reload_set) begin
      reload <= 1'b1;
    end else if (state == ST_IDLE && !copy_start && want_switch) begin
      reload <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cmd_word <= 16'h0000;
    end else begin
      cmd_word <= (set_word & fb_cmd) | (~set_word & term_sync);
    end
  end

  assign active_set_indicator = active;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  logic [31:0] sw_wait;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sw_wait <= 32'h0;
    end else if (want_switch && !copy_start) begin
      sw_wait <= sw_wait + 32'h1;
    end else begin
      sw_wait <= 32'h0;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_fetch_apply;
    state == ST_FETCH ##1 state == ST_APPLY;
  endsequence

  sequence s_launch;
    state == ST_IDLE && !copy_start && want_switch;
  endsequence

  a_index_bits: assert property (s_launch ##0 in_range(sel_idx, set_count_config) |=>
                                 pend_idx == {$past(sel_sync[1]), $past(sel_sync[0])})
    else $error("pending index not formed from select bits");
  a_count_range: assert property (set_count_config >= 3'h2 && set_count_config <= 3'h4)
    else $error("set count outside 2..4");
  a_count_gated: assert property ($changed(set_count_config) |-> $past(commissioning_state) == 4'hf)
    else $error("set count changed outside editing state");
  a_indicator_pin: assert property (rvalid && $past(rd_pend) && $past(rd_addr) == `CSS_REG_ACTIVE
                                    |-> rdata[1:0] == $past(active_set_indicator))
    else $error("active register disagrees with indicator");
  a_copy_clears: assert property ($rose(copy_start) |-> ##[1:4] !copy_start)
    else $error("copy start not cleared");
  a_copy_writes: assert property (state == ST_COPY |-> mem_we && mem_waddr == copy_tgt && mem_wdata == mem_rd_b)
    else $error("copy did not write target");
  a_switch_bound: assert property (sw_wait < SWITCH_CYC)
    else $error("switchover exceeded bound");
  a_switch_steps: assert property (s_launch |=> s_fetch_apply ##1 active == $past(pend_idx))
    else $error("switchover sequence broken");
  a_cmd_route: assert property (cmd_word == $past((set_word & fb_cmd) | (~set_word & term_sync)))
    else $error("command bits not routed by active set");
  a_apply_order: assert property ($changed(active) |-> $past(state) == ST_APPLY
                                  && $past(set_word) == set_word)
    else $error("indicator moved before set applied");

endmodule // css_switch

// File: test/css_far_side.sv
/*
  Far-side model: terminal strip and fieldbus master feeding the switch.
  Assumes the bench sets the wanted levels; pins move just after a rising edge.
*/
`timescale 1ns/1ps

module css_far_side
  import css_pkg::*;
(
  input  wire logic         aclk,
  input  wire css_idx_type  sel_req,
  input  wire css_word_type term_req,
  input  wire css_word_type fb_req,
  output logic              set_select_bit_low,
  output logic              set_select_bit_high,
  output css_word_type      term_cmd,
  output css_word_type      fb_cmd
);

  // Select bits routed from control signals of the user's choice
  always @(posedge aclk) begin
    set_select_bit_low  <= sel_req[0];
    set_select_bit_high <= sel_req[1];
  end

  always @(posedge aclk) begin
    term_cmd <= term_req;
    fb_cmd   <= fb_req;
  end

endmodule // css_far_side

// File: test/css_switch_test.sv
/*
  Self-checking bench of the command set switch: AXI4-Lite tasks and pin scenarios.
  Assumes css_far_side drives the select pins and the two command words.
*/
`timescale 1ns/1ps
`include "css_defines.svh"

module css_switch_test
  import css_pkg::*;
;
  logic                   aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic                   awready, wready, bvalid, arready, rvalid, sel_lo, sel_hi;
  logic [`CSS_ADDR_W-1:0] awaddr, araddr;
  logic [31:0]            wdata, rdata, seen;
  logic [1:0]             bresp, rresp, resp;
  css_idx_type            sel_req, active_set_indicator;
  css_word_type           term_req, fb_req, term_cmd, fb_cmd, cmd_word;
  css_word_type           words [4];
  int                     n_fail, comparisons, n, expc;

  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  css_far_side far (.aclk(aclk), .sel_req(sel_req), .term_req(term_req), .fb_req(fb_req),
    .set_select_bit_low(sel_lo), .set_select_bit_high(sel_hi), .term_cmd(term_cmd), .fb_cmd(fb_cmd));

  css_switch #(.SWITCH_CYC(64)) DUT (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
    .awprot(3'h0), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hf),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arprot(3'h0), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .set_select_bit_low(sel_lo),
    .set_select_bit_high(sel_hi), .term_cmd(term_cmd), .fb_cmd(fb_cmd), .cmd_word(cmd_word),
    .active_set_indicator(active_set_indicator));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      n_fail++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask

  // Every open-ended wait goes through here so none can hang
  task automatic tick(inout int k);
    @(posedge aclk);
    k++;
    if (k > 2000) begin
      n_fail++;
      $display("[ERR] %0t wait limit seen %h expected %h", $time, k, 2000);
      finish_test();
    end
  endtask

  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int k;
    k = 0;
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin tick(k); end while (awready !== 1'b1 || wready !== 1'b1);
    awvalid <= 1'b0;
    wvalid  <= 1'b0;
    do begin tick(k); end while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
    // Extra edge keeps bready from two assignments in one step
    tick(k);
  endtask

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int k;
    k = 0;
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin tick(k); end while (arready !== 1'b1);
    arvalid <= 1'b0;
    do begin tick(k); end while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    tick(k);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    axi_write(a, d, resp);
    check(resp, `CSS_RESP_OKAY);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    axi_read(a, seen, resp);
    check(resp, `CSS_RESP_OKAY);
    check(seen, e);
  endtask

  function automatic css_word_type mix(input css_word_type w);
    return (w & fb_req) | (~w & term_req);
  endfunction

  task automatic select(input css_idx_type i);
    int k;
    k = 0;
    sel_req <= i;
    do begin tick(k); end while (active_set_indicator !== i);
    check(k < 100, 1'b1);
    check(cmd_word, mix(words[i]));
    rd_chk(`CSS_REG_ACTIVE, {30'h0, i});
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    awaddr   = '0;
    araddr   = '0;
    wdata    = '0;
    sel_req  = 2'h0;
    term_req = 16'h3c3c;
    fb_req   = 16'hc3c3;
    words    = '{16'h0000, 16'hffff, 16'h00ff, 16'ha5a5};
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    rd_chk(`CSS_REG_COUNT, 32'h2);
    rd_chk(`CSS_REG_COMM, 32'h0);
    rd_chk(`CSS_REG_ACTIVE, 32'h0);
    axi_read(8'h20, seen, resp);
    check(resp, `CSS_RESP_SLVERR);
    check(seen, 32'h0);
    axi_write(8'h24, 32'h1, resp);
    check(resp, `CSS_RESP_SLVERR);
    wr(`CSS_REG_COUNT, 32'h4);
    rd_chk(`CSS_REG_COUNT, 32'h2);
    wr(`CSS_REG_COMM, {28'h0, `CSS_COMM_EDIT});
    expc = 2;
    for (int v = 1; v <= 5; v++) begin
      wr(`CSS_REG_COUNT, 32'(v));
      if (v >= 2 && v <= 4) begin
        expc = v;
      end
      rd_chk(`CSS_REG_COUNT, 32'(expc));
    end
    wr(`CSS_REG_COMM, {28'h0, `CSS_COMM_READY});
    for (int i = 0; i < 4; i++) begin
      wr(`CSS_REG_SET0 + 8'(4 * i), {16'h0, words[i]});
      rd_chk(`CSS_REG_SET0 + 8'(4 * i), {16'h0, words[i]});
    end
    // Order 1, 0, 3, 2 toggles the low select bit alone and both bits together
    for (int k = 0; k < 4; k++) begin
      select(css_idx_type'(k ^ 1));
    end
    // Copy set 3 onto the live set 2
    wr(`CSS_REG_COPY, 32'h123);
    n = 0;
    do begin
      axi_read(`CSS_REG_COPY, seen, resp);
      n++;
    end while (seen[8] !== 1'b0 && n < 20);
    check(seen[8], 1'b0);
    words[2] = words[3];
    rd_chk(`CSS_REG_SET0 + 8'h8, {16'h0, words[2]});
    n = 0;
    while (cmd_word !== mix(words[2]) && n < 50) begin
      tick(n);
    end
    check(cmd_word, mix(words[2]));
    // Index beyond a shrunk count must leave the active set alone
    wr(`CSS_REG_COMM, {28'h0, `CSS_COMM_EDIT});
    wr(`CSS_REG_COUNT, 32'h3);
    wr(`CSS_REG_COMM, {28'h0, `CSS_COMM_READY});
    sel_req <= 2'h3;
    repeat (12) @(posedge aclk);
    check(active_set_indicator, 2'h2);
    // A copy onto a set beyond the count is dropped
    wr(`CSS_REG_COPY, 32'h130);
    rd_chk(`CSS_REG_COPY, 32'h30);
    rd_chk(`CSS_REG_SET0 + 8'hc, {16'h0, words[3]});
    select(2'h0);
    finish_test();
  end

endmodule // css_switch_test
